// file: core/otc_crc_step.sv
`timescale 1ns/1ps
module otc_crc_step (
    input wire logic [31:0] crc_i,
    input wire logic [7:0] byte_i,
    output logic [31:0] crc_o
);
    always_comb begin
        logic [31:0] c;
        c = crc_i ^ {24'h000000, byte_i};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ otc_pkg::CRC_POLY) : (c >> 1);
        end
        crc_o = c;
    end
endmodule : otc_crc_step

// file: core/otc_pkg.sv
package otc_pkg;

    localparam logic [15:0] ETYPE_POS = 16'h000C;
    localparam logic [15:0] MSG_POS = 16'h000E;
    localparam logic [15:0] DOMAIN_POS = 16'h0012;
    localparam logic [15:0] CF_POS = 16'h0016;
    localparam logic [15:0] CF_LAST_POS = 16'h001D;
    localparam logic [15:0] RSV_POS = 16'h001E;
    localparam logic [15:0] RSV_LAST_POS = 16'h0021;
    localparam logic [15:0] DECIDE_POS = 16'h0022;
    localparam logic [15:0] SEQ_POS = 16'h002C;
    localparam logic [15:0] SEQ_LAST_POS = 16'h002D;
    localparam logic [15:0] FCS_BYTES = 16'h0004;

    localparam int LINE_DEPTH = 16;
    localparam logic [4:0] DRAIN_LAST = 5'h0F;
    localparam logic [3:0] SIZE_CF = 4'h8;
    localparam logic [3:0] SIZE_RSV = 4'h4;
    localparam logic [3:0] SIZE_NONE = 4'h0;

    localparam logic [15:0] PTP_ETYPE = 16'h88F7;
    localparam logic [3:0] MSG_SYNC = 4'h0;
    localparam logic [3:0] MSG_DREQ = 4'h1;
    localparam logic [3:0] MSG_PREQ = 4'h2;
    localparam logic [3:0] MSG_PRESP = 4'h3;

    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
    localparam logic [15:0] SCALED_FRAC = 16'h0000;
    localparam logic [15:0] SCALED_TOP = 16'h0000;

    typedef enum logic [4:0] {
        MODE_OFF = 5'h01,
        MODE_SPLIT_EGR = 5'h02,
        MODE_CARRY_ING = 5'h04,
        MODE_CARRY_EGR = 5'h08,
        MODE_PEER_ING = 5'h10
    } otc_mode_e;

    typedef enum logic [5:0] {
        ACT_IGNORE = 6'h01,
        ACT_ADD = 6'h02,
        ACT_SUB_ADD = 6'h04,
        ACT_PEER_SUB = 6'h08,
        ACT_WRITE = 6'h10,
        ACT_SAVE = 6'h20
    } otc_action_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_DRAIN = 3'h4
    } otc_state_e;

endpackage : otc_pkg

// file: core/otc_rewriter.sv
`timescale 1ns/1ps
// Contract
// R1 - Split egress Sync/Delay_req of our domain: Add action on 8-byte correction field.
// R2 - Unmatched frame passes unchanged; held stamp is discarded.
// R3 - Add action sums current transmit stamp with analyzer's correction field.
// R4 - Rewritten bytes take stamp unit output; FCS is regenerated.
// R5 - Modified frame that arrived with bad FCS leaves with inverted new FCS.
// R6 - Split egress: field plus stamp plus latency; Delay_req also minus asymmetry.
// R7 - Carried ingress: receive stamp into reserved bytes; Sync adds asymmetry.
// R8 - Carried ingress does no residence arithmetic; egress does it all.
// R9 - Carried egress: field plus transmit stamp minus stamp from reserved bytes.
// R10 - Carried egress clears the reserved bytes to zero.
// R11 - Carried egress Delay_req also subtracts asymmetry after the stamp.
// R12 - System keeps Sync/Delay_req detectable at both ingress and egress.
// R13 - Peer mode Sync gains residence time and arrival link delay.
// R14 - Peer ingress Sync: subtract stamp, add link delay and asymmetry.
// R15 - Peer ingress Pdelay frames: nanosecond receive stamp into reserved bytes.
// R16 - Peer ingress Pdelay_resp also adds asymmetry to correction field.
// R17 - Standard method keeps Pdelay_req transmit stamp t3 for the CPU.
// R18 - Engine computes link delay as half of both turnaround spans.
// R19 - Modified method: engine sends software t3, zero field, within one second.
// R20 - Modified method: egress handles Pdelay_req as end-to-end carried egress.
// R21 - Split ingress subtracts receive stamp from correction field.
// R22 - Saved transmit stamp is kept paired with its frame identifier.
// R23 - Field arithmetic is signed 64-bit scaled nanoseconds, wrapping.
// R24 - Action and offsets are ready before targeted bytes pass rewrite point.
module otc_rewriter (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire otc_pkg::otc_mode_e mode_i,
    input wire logic [7:0] domain_i,
    input wire logic pdelay_as_e2e_i,
    input wire logic [31:0] raw_nanosecond_capture_i,
    input wire logic [31:0] local_latency_offset_i,
    input wire logic [63:0] asymmetry_i,
    input wire logic [63:0] link_delay_value_i,
    input wire logic in_valid_i,
    input wire logic [7:0] in_data_i,
    input wire logic in_last_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [7:0] out_data_o,
    output logic out_last_o,
    output otc_pkg::otc_action_e frame_action_o,
    output logic [3:0] frame_size_o,
    output logic saved_valid_o,
    output logic [31:0] saved_stamp_o,
    output logic [15:0] saved_seq_o
);
    otc_pkg::otc_state_e state_reg, state_next;
    otc_pkg::otc_action_e act_reg, act_next;
    logic [15:0] in_cnt_reg, in_cnt_next, len_reg, len_next;
    logic [15:0] etype_reg, etype_next, seq_reg, seq_next;
    logic [3:0] msg_reg, msg_next, size_reg, size_next;
    logic [7:0] dom_reg, dom_next;
    logic [63:0] cf_reg, cf_next, new_cf_reg, new_cf_next;
    logic [31:0] rsv_reg, rsv_next, new_rsv_reg, new_rsv_next, stamp_reg, stamp_next;
    logic [31:0] crc_in_reg, crc_in_next, crc_in_step;
    logic wr_cf_reg, wr_cf_next, wr_rsv_reg, wr_rsv_next, bad_reg, bad_next;
    logic [4:0] drain_reg, drain_next;
    logic saved_valid_next;
    logic [31:0] saved_stamp_next;
    logic [15:0] saved_seq_next;
    logic [7:0] line_reg [otc_pkg::LINE_DEPTH];
    logic [7:0] line_next [otc_pkg::LINE_DEPTH];
    logic lval_reg [otc_pkg::LINE_DEPTH];
    logic lval_next [otc_pkg::LINE_DEPTH];
    logic accept, shift, ingress, match;
    logic is_sync, is_dreq, is_preq, is_presp;
    logic [63:0] ts_scaled, asym_dreq, span_scaled;
    logic [31:0] span_ns;

    logic [15:0] out_cnt_reg, out_cnt_next;
    logic [31:0] crc_out_reg, crc_out_next, crc_out_step, fcs_word;
    logic out_valid_next, out_last_next;
    logic [7:0] out_data_next, head_byte, mod_byte;

    assign in_ready_o = (state_reg != otc_pkg::ST_DRAIN);
    assign accept = in_valid_i && in_ready_o;
    assign shift = accept || (state_reg == otc_pkg::ST_DRAIN);
    assign ingress = (mode_i == otc_pkg::MODE_CARRY_ING) || (mode_i == otc_pkg::MODE_PEER_ING);
    // R12 frame detection
    assign match = (etype_reg == otc_pkg::PTP_ETYPE) && (dom_reg == domain_i);
    assign is_sync = match && (msg_reg == otc_pkg::MSG_SYNC);
    assign is_dreq = match && (msg_reg == otc_pkg::MSG_DREQ);
    assign is_preq = match && (msg_reg == otc_pkg::MSG_PREQ);
    assign is_presp = match && (msg_reg == otc_pkg::MSG_PRESP);
    // R23 scaled nanoseconds
    assign ts_scaled = {otc_pkg::SCALED_TOP, stamp_reg, otc_pkg::SCALED_FRAC};
    assign asym_dreq = is_dreq ? asymmetry_i : 64'h0000000000000000;
    // Sub-second stamps wrap once per second, so a negative span gains one second.
    assign span_ns = (stamp_reg >= rsv_reg) ? (stamp_reg - rsv_reg)
                                            : (stamp_reg - rsv_reg + otc_pkg::NS_PER_SEC);
    assign span_scaled = {otc_pkg::SCALED_TOP, span_ns, otc_pkg::SCALED_FRAC};

    otc_crc_step u_crc_in (
        .crc_i(crc_in_reg),
        .byte_i(in_data_i),
        .crc_o(crc_in_step)
    );

    always_comb begin
        state_next = state_reg;
        act_next = act_reg;
        in_cnt_next = in_cnt_reg;
        len_next = len_reg;
        etype_next = etype_reg;
        seq_next = seq_reg;
        msg_next = msg_reg;
        size_next = size_reg;
        dom_next = dom_reg;
        cf_next = cf_reg;
        new_cf_next = new_cf_reg;
        rsv_next = rsv_reg;
        new_rsv_next = new_rsv_reg;
        stamp_next = stamp_reg;
        crc_in_next = crc_in_reg;
        wr_cf_next = wr_cf_reg;
        wr_rsv_next = wr_rsv_reg;
        bad_next = bad_reg;
        drain_next = drain_reg;
        saved_valid_next = 1'b0;
        saved_stamp_next = saved_stamp_o;
        saved_seq_next = saved_seq_o;
        for (int i = 0; i < otc_pkg::LINE_DEPTH; i++) begin
            line_next[i] = line_reg[i];
            lval_next[i] = lval_reg[i];
        end
        // R24 delay line
        if (shift) begin
            line_next[0] = in_data_i;
            lval_next[0] = accept;
            for (int i = 1; i < otc_pkg::LINE_DEPTH; i++) begin
                line_next[i] = line_reg[i - 1];
                lval_next[i] = lval_reg[i - 1];
            end
        end
        if (accept) begin
            in_cnt_next = in_cnt_reg + 16'h0001;
            crc_in_next = crc_in_step;
            if (in_cnt_reg == otc_pkg::ETYPE_POS) begin
                etype_next[15:8] = in_data_i;
            end
            if (in_cnt_reg == otc_pkg::ETYPE_POS + 16'h0001) begin
                etype_next[7:0] = in_data_i;
            end
            if (in_cnt_reg == otc_pkg::MSG_POS) begin
                msg_next = in_data_i[3:0];
            end
            if (in_cnt_reg == otc_pkg::DOMAIN_POS) begin
                dom_next = in_data_i;
            end
            if (in_cnt_reg >= otc_pkg::CF_POS && in_cnt_reg <= otc_pkg::CF_LAST_POS) begin
                cf_next = {cf_reg[55:0], in_data_i};
            end
            if (in_cnt_reg >= otc_pkg::RSV_POS && in_cnt_reg <= otc_pkg::RSV_LAST_POS) begin
                rsv_next = {rsv_reg[23:0], in_data_i};
            end
            if (in_cnt_reg >= otc_pkg::SEQ_POS && in_cnt_reg <= otc_pkg::SEQ_LAST_POS) begin
                seq_next = {seq_reg[7:0], in_data_i};
            end
            if (state_reg == otc_pkg::ST_IDLE) begin
                // R2 fresh frame drops old stamp
                state_next = otc_pkg::ST_RUN;
                etype_next = 16'h0000;
                act_next = otc_pkg::ACT_IGNORE;
                size_next = otc_pkg::SIZE_NONE;
                wr_cf_next = 1'b0;
                wr_rsv_next = 1'b0;
                len_next = 16'hFFFF;
                stamp_next = ingress ? (raw_nanosecond_capture_i - local_latency_offset_i)
                                     : (raw_nanosecond_capture_i + local_latency_offset_i);
            end
            if (in_cnt_reg == otc_pkg::DECIDE_POS) begin
                case (mode_i)
                    otc_pkg::MODE_SPLIT_EGR: begin
                        if (is_sync || is_dreq) begin
                            // R1 split egress add
                            act_next = otc_pkg::ACT_ADD;
                            size_next = otc_pkg::SIZE_CF;
                            wr_cf_next = 1'b1;
                            // R3 R6 add stamp
                            new_cf_next = cf_reg + ts_scaled - asym_dreq;
                        end else if (is_preq) begin
                            // R17 keep t3
                            act_next = otc_pkg::ACT_SAVE;
                        end
                    end
                    otc_pkg::MODE_CARRY_ING: begin
                        if (is_sync || is_dreq) begin
                            // R7 R8 stamp, plus asymmetry for Sync
                            act_next = otc_pkg::ACT_WRITE;
                            size_next = otc_pkg::SIZE_RSV;
                            wr_rsv_next = 1'b1;
                            new_rsv_next = stamp_reg;
                            wr_cf_next = is_sync;
                            new_cf_next = cf_reg + asymmetry_i;
                        end
                    end
                    otc_pkg::MODE_CARRY_EGR: begin
                        // R20 Pdelay_req as carried egress
                        if (is_sync || is_dreq || (is_preq && pdelay_as_e2e_i)) begin
                            act_next = otc_pkg::ACT_SUB_ADD;
                            size_next = otc_pkg::SIZE_CF;
                            wr_cf_next = 1'b1;
                            // R9 R11 residence span
                            new_cf_next = cf_reg + span_scaled - asym_dreq;
                            // R10 clear reserved
                            wr_rsv_next = 1'b1;
                            new_rsv_next = 32'h00000000;
                        end
                    end
                    otc_pkg::MODE_PEER_ING: begin
                        if (is_sync) begin
                            // R13 R14 R21 peer subtract
                            act_next = otc_pkg::ACT_PEER_SUB;
                            size_next = otc_pkg::SIZE_CF;
                            wr_cf_next = 1'b1;
                            new_cf_next = cf_reg - ts_scaled + link_delay_value_i + asymmetry_i;
                        end else if (is_preq || is_presp) begin
                            // R15 nanosecond stamp
                            act_next = otc_pkg::ACT_WRITE;
                            size_next = otc_pkg::SIZE_RSV;
                            wr_rsv_next = 1'b1;
                            new_rsv_next = stamp_reg;
                            // R16 response asymmetry
                            wr_cf_next = is_presp;
                            new_cf_next = cf_reg + asymmetry_i;
                        end
                    end
                    default: begin
                        act_next = otc_pkg::ACT_IGNORE;
                    end
                endcase
            end
            if (in_last_i) begin
                state_next = otc_pkg::ST_DRAIN;
                drain_next = 5'h00;
                len_next = in_cnt_reg + 16'h0001;
                // R5 incoming check
                bad_next = (crc_in_step != otc_pkg::CRC_RESIDUE);
                // R22 stamp with identifier
                if (act_reg == otc_pkg::ACT_SAVE) begin
                    saved_valid_next = 1'b1;
                    saved_stamp_next = stamp_reg;
                    saved_seq_next = seq_next;
                end
            end
        end
        if (state_reg == otc_pkg::ST_DRAIN) begin
            drain_next = drain_reg + 5'h01;
            if (drain_reg == otc_pkg::DRAIN_LAST) begin
                state_next = otc_pkg::ST_IDLE;
                crc_in_next = otc_pkg::CRC_INIT;
                in_cnt_next = 16'h0000;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= otc_pkg::ST_IDLE;
            act_reg <= otc_pkg::ACT_IGNORE;
            in_cnt_reg <= 16'h0000;
            len_reg <= 16'hFFFF;
            etype_reg <= 16'h0000;
            seq_reg <= 16'h0000;
            msg_reg <= 4'h0;
            size_reg <= 4'h0;
            dom_reg <= 8'h00;
            cf_reg <= 64'h0000000000000000;
            new_cf_reg <= 64'h0000000000000000;
            rsv_reg <= 32'h00000000;
            new_rsv_reg <= 32'h00000000;
            stamp_reg <= 32'h00000000;
            crc_in_reg <= otc_pkg::CRC_INIT;
            wr_cf_reg <= 1'b0;
            wr_rsv_reg <= 1'b0;
            bad_reg <= 1'b0;
            drain_reg <= 5'h00;
            saved_valid_o <= 1'b0;
            saved_stamp_o <= 32'h00000000;
            saved_seq_o <= 16'h0000;
            for (int i = 0; i < otc_pkg::LINE_DEPTH; i++) begin
                line_reg[i] <= 8'h00;
                lval_reg[i] <= 1'b0;
            end
        end else begin
            state_reg <= state_next;
            act_reg <= act_next;
            in_cnt_reg <= in_cnt_next;
            len_reg <= len_next;
            etype_reg <= etype_next;
            seq_reg <= seq_next;
            msg_reg <= msg_next;
            size_reg <= size_next;
            dom_reg <= dom_next;
            cf_reg <= cf_next;
            new_cf_reg <= new_cf_next;
            rsv_reg <= rsv_next;
            new_rsv_reg <= new_rsv_next;
            stamp_reg <= stamp_next;
            crc_in_reg <= crc_in_next;
            wr_cf_reg <= wr_cf_next;
            wr_rsv_reg <= wr_rsv_next;
            bad_reg <= bad_next;
            drain_reg <= drain_next;
            saved_valid_o <= saved_valid_next;
            saved_stamp_o <= saved_stamp_next;
            saved_seq_o <= saved_seq_next;
            for (int i = 0; i < otc_pkg::LINE_DEPTH; i++) begin
                line_reg[i] <= line_next[i];
                lval_reg[i] <= lval_next[i];
            end
        end
    end

    assign frame_action_o = act_reg;
    assign frame_size_o = size_reg;
    assign head_byte = line_reg[otc_pkg::LINE_DEPTH - 1];
    // R5 bad frames keep a bad checksum
    assign fcs_word = bad_reg ? crc_out_reg : ~crc_out_reg;

    otc_crc_step u_crc_out (
        .crc_i(crc_out_reg),
        .byte_i(mod_byte),
        .crc_o(crc_out_step)
    );

    always_comb begin
        int k;
        k = 0;
        mod_byte = head_byte;
        // R4 field replace
        if (wr_cf_reg && out_cnt_reg >= otc_pkg::CF_POS && out_cnt_reg <= otc_pkg::CF_LAST_POS) begin
            k = 7 - int'(out_cnt_reg - otc_pkg::CF_POS);
            mod_byte = new_cf_reg[k * 8 +: 8];
        end
        if (wr_rsv_reg && out_cnt_reg >= otc_pkg::RSV_POS
                && out_cnt_reg <= otc_pkg::RSV_LAST_POS) begin
            k = 3 - int'(out_cnt_reg - otc_pkg::RSV_POS);
            mod_byte = new_rsv_reg[k * 8 +: 8];
        end
        out_cnt_next = out_cnt_reg;
        crc_out_next = crc_out_reg;
        out_valid_next = 1'b0;
        out_last_next = 1'b0;
        out_data_next = out_data_o;
        if (shift && lval_reg[otc_pkg::LINE_DEPTH - 1]) begin
            out_valid_next = 1'b1;
            out_cnt_next = out_cnt_reg + 16'h0001;
            out_data_next = mod_byte;
            if (out_cnt_reg + otc_pkg::FCS_BYTES >= len_reg) begin
                // R4 fresh FCS
                k = int'(out_cnt_reg + otc_pkg::FCS_BYTES - len_reg);
                out_data_next = (wr_cf_reg || wr_rsv_reg) ? fcs_word[k * 8 +: 8] : head_byte;
            end else begin
                crc_out_next = crc_out_step;
            end
            if (out_cnt_reg + 16'h0001 == len_reg) begin
                out_last_next = 1'b1;
                out_cnt_next = 16'h0000;
                crc_out_next = otc_pkg::CRC_INIT;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            out_cnt_reg <= 16'h0000;
            crc_out_reg <= otc_pkg::CRC_INIT;
            out_valid_o <= 1'b0;
            out_last_o <= 1'b0;
            out_data_o <= 8'h00;
        end else begin
            out_cnt_reg <= out_cnt_next;
            crc_out_reg <= crc_out_next;
            out_valid_o <= out_valid_next;
            out_last_o <= out_last_next;
            out_data_o <= out_data_next;
        end
    end
endmodule : otc_rewriter

// file: sim/otc_mac_sink.sv
`timescale 1ns/1ps
module otc_mac_sink (
    input wire logic core_clk_i,
    input wire logic clr_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    output logic [7:0] got_o [0:63],
    output int n_o
);
    always_ff @(posedge core_clk_i) begin
        if (clr_i) begin
            n_o <= 0;
        end else if (valid_i === 1'b1) begin
            if (n_o < 64) begin
                got_o[n_o] <= data_i;
            end
            n_o <= n_o + 1;
        end
    end
endmodule : otc_mac_sink

// file: sim/otc_rewriter_asserts.sv
`timescale 1ns/1ps
module otc_rewriter_chk (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    input wire logic in_last_i,
    input wire logic in_ready_o,
    input wire logic out_valid_o,
    input wire logic out_last_o,
    input wire otc_pkg::otc_action_e frame_action_o,
    input wire logic [3:0] frame_size_o,
    input wire logic saved_valid_o,
    input wire logic [31:0] saved_stamp_o,
    input wire logic [15:0] saved_seq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    sequence s_end;
        in_valid_i && in_ready_o && in_last_i;
    endsequence
    // Two runs of eight keep each repetition count small.
    sequence s_drain;
        (!in_ready_o)[*8] ##1 (!in_ready_o)[*8] ##1 in_ready_o;
    endsequence
    chk_drain_len: assert property (disable iff (reset_i) s_end |=> s_drain)
        else $error("drain length wrong");
    chk_ready_reset: assert property (reset_i |=> in_ready_o)
        else $error("not ready in reset");
    chk_reset_vals: assert property (reset_i |=> frame_action_o == otc_pkg::ACT_IGNORE
        && frame_size_o == 4'h0 && !out_valid_o && !saved_valid_o)
        else $error("reset values wrong");
    chk_cf_size: assert property (disable iff (reset_i) (frame_action_o inside
        {otc_pkg::ACT_ADD, otc_pkg::ACT_SUB_ADD, otc_pkg::ACT_PEER_SUB})
        |-> frame_size_o == otc_pkg::SIZE_CF)
        else $error("field size not eight");
    chk_rsv_size: assert property (disable iff (reset_i) frame_action_o == otc_pkg::ACT_WRITE
        |-> frame_size_o == otc_pkg::SIZE_RSV)
        else $error("reserved size not four");
    chk_save_pulse: assert property (disable iff (reset_i) s_end
        ##0 frame_action_o == otc_pkg::ACT_SAVE |=> saved_valid_o ##1 !saved_valid_o)
        else $error("save pulse wrong");
    chk_stamp_hold: assert property (disable iff (reset_i) !saved_valid_o
        |-> $stable(saved_stamp_o) && $stable(saved_seq_o))
        else $error("saved pair moved");
    chk_last_delay: assert property (disable iff (reset_i) s_end |-> ##17 out_last_o && out_valid_o)
        else $error("last byte late");
endmodule : otc_rewriter_chk
bind otc_rewriter otc_rewriter_chk chk_u (.core_clk_i, .reset_i, .in_valid_i, .in_last_i,
    .in_ready_o, .out_valid_o, .out_last_o, .frame_action_o, .frame_size_o, .saved_valid_o,
    .saved_stamp_o, .saved_seq_o);

// file: sim/otc_rewriter_tb.sv
`timescale 1ns/1ps
module otc_rewriter_tb;
    logic core_clk_i, reset_i, e2e, in_valid_i, in_last_i, clr;
    otc_pkg::otc_mode_e mode_i;
    logic [7:0] domain_i, in_data_i, out_data_o;
    logic [31:0] raw, lat, saved_stamp_o;
    logic [63:0] asym, link;
    logic in_ready_o, out_valid_o, out_last_o, saved_valid_o;
    otc_pkg::otc_action_e frame_action_o;
    logic [3:0] frame_size_o;
    logic [15:0] saved_seq_o;
    logic [7:0] fr [0:63];
    logic [7:0] ex [0:63];
    logic [7:0] got [0:63];
    int n_got, n_save, n_mismatch, total_checks;
    otc_rewriter dut_u (.core_clk_i, .reset_i, .mode_i, .domain_i, .pdelay_as_e2e_i(e2e),
        .raw_nanosecond_capture_i(raw), .local_latency_offset_i(lat), .asymmetry_i(asym),
        .link_delay_value_i(link), .in_valid_i, .in_data_i, .in_last_i, .in_ready_o,
        .out_valid_o, .out_data_o, .out_last_o, .frame_action_o, .frame_size_o,
        .saved_valid_o, .saved_stamp_o, .saved_seq_o);
    otc_mac_sink sink_u (.core_clk_i, .clr_i(clr), .valid_i(out_valid_o), .data_i(out_data_o),
        .got_o(got), .n_o(n_got));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (saved_valid_o === 1'b1) n_save <= n_save + 1;
    end
    function automatic logic [31:0] crc_of(input logic [7:0] b [0:63]);
        logic [31:0] c;
        c = otc_pkg::CRC_INIT;
        for (int i = 0; i < 60; i++) begin
            c = c ^ {24'h0, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ otc_pkg::CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction : crc_of
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_word
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // A small field makes peer subtraction wrap.
    task automatic run(input otc_pkg::otc_mode_e m, input logic [3:0] msg, input logic [7:0] dom,
        input logic bad, input logic [31:0] rsv);
        logic [63:0] cf, c2;
        logic [31:0] te, ti, r2, f;
        logic modf;
        cf = (e2e && msg == 4'h2) ? 64'h0 : 64'h12_0000;
        te = raw + lat;
        ti = raw - lat;
        c2 = cf;
        r2 = rsv;
        modf = 1'b0;
        for (int i = 0; i < 60; i++) fr[i] = 8'(i * 7);
        {fr[12], fr[13], fr[14], fr[18], fr[44], fr[45]} = {16'h88F7, 4'h0, msg, dom, 16'h1234};
        for (int i = 0; i < 8; i++) fr[22 + i] = cf[63 - 8 * i -: 8];
        for (int i = 0; i < 4; i++) fr[30 + i] = rsv[31 - 8 * i -: 8];
        f = crc_of(fr);
        for (int i = 0; i < 4; i++) fr[60 + i] = f[8 * i +: 8];
        if (bad) fr[60] = ~fr[60];
        if (dom == domain_i) begin
            case (m)
                otc_pkg::MODE_SPLIT_EGR: if (msg <= otc_pkg::MSG_DREQ) begin
                    c2 = cf + {16'h0, te, 16'h0} - (msg == otc_pkg::MSG_DREQ ? asym : 64'h0);
                    modf = 1'b1;
                end
                otc_pkg::MODE_CARRY_ING: if (msg <= otc_pkg::MSG_DREQ) begin
                    r2 = ti;
                    c2 = cf + (msg == otc_pkg::MSG_SYNC ? asym : 64'h0);
                    modf = 1'b1;
                end
                otc_pkg::MODE_CARRY_EGR: if (msg <= otc_pkg::MSG_DREQ || (e2e && msg == 4'h2)) begin
                    c2 = cf + {16'h0, (te - rsv) % otc_pkg::NS_PER_SEC, 16'h0};
                    c2 = c2 - (msg == otc_pkg::MSG_DREQ ? asym : 64'h0);
                    r2 = 32'h0;
                    modf = 1'b1;
                end
                otc_pkg::MODE_PEER_ING: begin
                    if (msg == otc_pkg::MSG_SYNC) c2 = cf - {16'h0, ti, 16'h0} + link + asym;
                    else r2 = ti;
                    if (msg == otc_pkg::MSG_PRESP) c2 = cf + asym;
                    modf = (msg != otc_pkg::MSG_DREQ);
                end
                default: ;
            endcase
        end
        ex = fr;
        if (modf) begin
            for (int i = 0; i < 8; i++) ex[22 + i] = c2[63 - 8 * i -: 8];
            for (int i = 0; i < 4; i++) ex[30 + i] = r2[31 - 8 * i -: 8];
            f = crc_of(ex) ^ {32{bad}};
            for (int i = 0; i < 4; i++) ex[60 + i] = f[8 * i +: 8];
        end
        mode_i = m;
        clr = 1'b1;
        @(negedge core_clk_i);
        clr = 1'b0;
        for (int i = 0; i < 64; i++) begin
            {in_valid_i, in_data_i, in_last_i} = {1'b1, fr[i], i == 63};
            @(negedge core_clk_i);
        end
        {in_valid_i, in_last_i} = 2'b00;
        repeat (22) @(negedge core_clk_i);
        cmp_word(32'(n_got), 32'd64);
        for (int i = 0; i < 64; i++) cmp_word({24'h0, got[i]}, {24'h0, ex[i]});
    endtask : run
    initial begin
        {reset_i, clr, e2e, in_valid_i, in_last_i, in_data_i} = {3'b100, 2'b00, 8'h00};
        mode_i = otc_pkg::MODE_OFF;
        {domain_i, n_save, n_mismatch, total_checks} = {8'h05, 96'h0};
        {raw, lat, asym, link} = {32'h0002_0000, 32'h0000_0100, 64'h3_8000, 64'h10_0000};
        repeat (4) @(negedge core_clk_i);
        reset_i = 1'b0;
        run(otc_pkg::MODE_SPLIT_EGR, 4'h0, 8'h05, 1'b0, 32'h0);
        run(otc_pkg::MODE_SPLIT_EGR, 4'h1, 8'h05, 1'b1, 32'h0);
        run(otc_pkg::MODE_SPLIT_EGR, 4'h0, 8'h06, 1'b0, 32'h0);
        run(otc_pkg::MODE_SPLIT_EGR, 4'h2, 8'h05, 1'b0, 32'h0);
        cmp_word({16'h0, saved_seq_o}, 32'h1234);
        cmp_word(saved_stamp_o, raw + lat);
        cmp_word(32'(n_save), 32'd1);
        run(otc_pkg::MODE_CARRY_ING, 4'h0, 8'h05, 1'b0, 32'h0);
        run(otc_pkg::MODE_CARRY_ING, 4'h1, 8'h05, 1'b0, 32'h55);
        run(otc_pkg::MODE_CARRY_EGR, 4'h0, 8'h05, 1'b0, 32'h1_8000);
        run(otc_pkg::MODE_CARRY_EGR, 4'h1, 8'h05, 1'b0, 32'h1_8000);
        e2e = 1'b1;
        run(otc_pkg::MODE_CARRY_EGR, 4'h2, 8'h05, 1'b0, 32'h1_F000);
        e2e = 1'b0;
        run(otc_pkg::MODE_CARRY_EGR, 4'h2, 8'h05, 1'b0, 32'h1_F000);
        run(otc_pkg::MODE_PEER_ING, 4'h0, 8'h05, 1'b0, 32'h0);
        run(otc_pkg::MODE_PEER_ING, 4'h2, 8'h05, 1'b0, 32'h0);
        run(otc_pkg::MODE_PEER_ING, 4'h3, 8'h05, 1'b1, 32'h0);
        run(otc_pkg::MODE_OFF, 4'h0, 8'h05, 1'b0, 32'h0);
        tally_and_finish();
    end
    // Tests take about 1200 cycles.
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : otc_rewriter_tb
